// ---- include/sasq_regs.svh ----
// timing counts, field positions and reset values of the sampling sequencer
`ifndef SASQ_REGS_SVH
`define SASQ_REGS_SVH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define SASQ_CLK_PERIOD_NS 4
`define SASQ_CH_TIME_NS 2000
`define SASQ_CH_CYC ((`SASQ_CH_TIME_NS) / (`SASQ_CLK_PERIOD_NS))
`define SASQ_INT_DIV 5'h19
`define SASQ_HOLD_HIGH_CYC 7'h40

// ----------------------------------------------------------------------------
// mode word fields
// ----------------------------------------------------------------------------
`define SASQ_MODE_CNT_LSB 0
`define SASQ_MODE_CNT_MSB 1
`define SASQ_MODE_BANK_BIT 2
`define SASQ_MODE_PDOWN_BIT 3
`define SASQ_MODE_RESET 4'h0

// ----------------------------------------------------------------------------
// result word
// ----------------------------------------------------------------------------
`define SASQ_RES_W 12
`define SASQ_RES_TOP_IDX 4'hB

`endif

// ---- include/sasq_pkg.sv ----
// types shared by the sampling sequencer and its conversion clock
package sasq_pkg;

  // --------------------------------------------------------------------------
  // sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b01,
    SQ_CONV = 2'b10
  } sasq_state_t;

  // --------------------------------------------------------------------------
  // state of the conversion clock selector
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic [6:0] hi_cnt;
    logic [4:0] div_cnt;
    logic int_sel;
    logic tick;
  } sasq_tmr_t;

  // --------------------------------------------------------------------------
  // state of the sequencer
  // --------------------------------------------------------------------------
  typedef struct packed {
    sasq_state_t state;
    logic cs_m;
    logic cs_s;
    logic wr_m;
    logic wr_s;
    logic rd_m;
    logic rd_s;
    logic trg_m;
    logic trg_s;
    logic trg_p;
    logic [3:0] md_m;
    logic [3:0] md_s;
    logic wr_act;
    logic [3:0] md_cap;
    logic [3:0] mode;
    logic rd_act;
    logic [1:0] rd_ptr;
    logic [3:0][11:0] mem;
    logic [11:0] dout;
    logic [11:0] work;
    logic [11:0] dac;
    logic [3:0] bit_idx;
    logic [1:0] ch_idx;
    logic [1:0] seq_last;
    logic seq_bank;
    logic [8:0] ch_cyc;
    logic [10:0] seq_cyc;
    logic hold;
    logic end_n;
  } sasq_seq_t;

endpackage : sasq_pkg

// ---- hdl/sasq_conv_clock.sv ----
// conversion clock: external pin edges or internal divider when the pin sits high
`timescale 1ns/1ps
`include "sasq_regs.svh"

module sasq_conv_clock (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic conv_clk_pin,
  output logic conv_tick,
  output logic int_clk_sel
);
  import sasq_pkg::*;

  sasq_tmr_t st_r;
  sasq_tmr_t st_nxt;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  // a pin held high longer than any legal external clock phase selects the
  // internal oscillator; any low level returns to the external clock
  always_comb begin
    st_nxt = st_r;
    st_nxt.pin_meta = conv_clk_pin;
    st_nxt.pin_sync = st_r.pin_meta;
    st_nxt.pin_prev = st_r.pin_sync;
    if (!st_r.pin_sync) begin
      st_nxt.hi_cnt = 7'h00;
      st_nxt.int_sel = 1'b0;
    end else if (st_r.hi_cnt != `SASQ_HOLD_HIGH_CYC) begin
      st_nxt.hi_cnt = st_r.hi_cnt + 7'h01;
    end else begin
      st_nxt.int_sel = 1'b1;
    end
    // internal divider free-runs so the internal rate is ready at once
    if (st_r.div_cnt == `SASQ_INT_DIV - 5'h01) begin
      st_nxt.div_cnt = 5'h00;
    end else begin
      st_nxt.div_cnt = st_r.div_cnt + 5'h01;
    end
    if (st_r.int_sel) begin
      st_nxt.tick = (st_r.div_cnt == `SASQ_INT_DIV - 5'h01);
    end else begin
      st_nxt.tick = st_r.pin_sync & ~st_r.pin_prev;
    end
    if (sys_rst) begin
      st_nxt = '0;
      // pin flops reset to the idle-high level so release shows no false edge
      st_nxt.pin_meta = 1'b1;
      st_nxt.pin_sync = 1'b1;
      st_nxt.pin_prev = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign conv_tick = st_r.tick;
  assign int_clk_sel = st_r.int_sel;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_int_clk_select: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.pin_sync && st_r.hi_cnt == `SASQ_HOLD_HIGH_CYC) |=> int_clk_sel)
    else $error("internal clock not chosen with pin held high");

  a_ext_clk_select: assert property (@(posedge clk) disable iff (sys_rst)
    (!st_r.pin_sync) |=> (!int_clk_sel ##1 (conv_tick == ($past(st_r.pin_sync) & !$past(st_r.pin_prev)))))
    else $error("external clock edge not followed");

endmodule : sasq_conv_clock

// ---- hdl/sasq_sequencer.sv ----
// four-channel simultaneous-sampling sequencer with parallel host port
`timescale 1ns/1ps
`include "sasq_regs.svh"

module sasq_sequencer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic sample_trigger_n,
  input wire logic conv_clk_pin,
  input wire logic [1:0] mode_select_bits,
  input wire logic shared_result0_mode2_i,
  input wire logic shared_result1_mode3_i,
  input wire logic cmp_hi,
  output logic [11:0] result_bits_o,
  output logic result_bits_oe,
  output logic end_of_seq_n,
  output logic [11:0] dac_code,
  output logic sample_hold,
  output logic bank_sel,
  output logic [1:0] chan_sel,
  output logic power_down,
  output logic int_clk_sel
);
  import sasq_pkg::*;

  sasq_seq_t st_r;
  sasq_seq_t st_nxt;
  logic conv_tick;
  logic rd_now;
  logic wr_now;
  logic trg_rise;
  logic store;
  logic [11:0] trial;
  logic [10:0] seq_lim;

  // --------------------------------------------------------------------------
  // conversion clock
  // --------------------------------------------------------------------------
  sasq_conv_clock u_conv_clock (
    .clk(clk),
    .sys_rst(sys_rst),
    .conv_clk_pin(conv_clk_pin),
    .conv_tick(conv_tick),
    .int_clk_sel(int_clk_sel)
  );

  // --------------------------------------------------------------------------
  // strobe decode from synchronised pins
  // --------------------------------------------------------------------------
  // select gates both strobes, so a strobe with select high does nothing
  assign rd_now = ~st_r.cs_s & ~st_r.rd_s;
  assign wr_now = ~st_r.cs_s & ~st_r.wr_s;
  assign trg_rise = st_r.trg_s & ~st_r.trg_p;
  assign trial = st_r.work | 12'(12'h001 << st_r.bit_idx);
  // a channel ends on its last bit trial or when its time budget runs out,
  // so a slow external clock cannot stretch a channel past its limit
  assign store = (st_r.state == SQ_CONV) &&
                 ((conv_tick && st_r.bit_idx == 4'h0) || st_r.ch_cyc == 9'(`SASQ_CH_CYC - 1));
  assign seq_lim = 11'(({9'h000, st_r.seq_last} + 11'h001) * 11'(`SASQ_CH_CYC));

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    // two-stage synchronisers for every pin except cmp_hi and sys_rst
    st_nxt.cs_m = cs_n;
    st_nxt.cs_s = st_r.cs_m;
    st_nxt.wr_m = wr_n;
    st_nxt.wr_s = st_r.wr_m;
    st_nxt.rd_m = rd_n;
    st_nxt.rd_s = st_r.rd_m;
    st_nxt.trg_m = sample_trigger_n;
    st_nxt.trg_s = st_r.trg_m;
    st_nxt.trg_p = st_r.trg_s;
    st_nxt.md_m = {shared_result1_mode3_i, shared_result0_mode2_i, mode_select_bits};
    st_nxt.md_s = st_r.md_m;

    // mode write: keep the last value seen while both strobes are low and
    // commit it when either one rises
    st_nxt.wr_act = wr_now;
    if (wr_now) begin
      st_nxt.md_cap = st_r.md_s;
    end
    if (st_r.wr_act && !wr_now) begin
      st_nxt.mode = st_r.md_cap;
    end

    // read port: load the word on the falling strobe, advance on release
    st_nxt.rd_act = rd_now;
    if (rd_now && !st_r.rd_act) begin
      st_nxt.dout = st_r.mem[st_r.rd_ptr];
      st_nxt.end_n = 1'b1;
    end
    if (st_r.rd_act && !rd_now) begin
      st_nxt.rd_ptr = st_r.rd_ptr + 2'h1;
    end

    // sequencer
    unique case (st_r.state)
      SQ_IDLE: begin
        // power-down mode does not start conversions
        if (trg_rise && !st_r.mode[`SASQ_MODE_PDOWN_BIT]) begin
          st_nxt.state = SQ_CONV;
          st_nxt.hold = 1'b1;
          st_nxt.seq_last = st_r.mode[`SASQ_MODE_CNT_MSB:`SASQ_MODE_CNT_LSB];
          st_nxt.seq_bank = st_r.mode[`SASQ_MODE_BANK_BIT];
          st_nxt.ch_idx = 2'h0;
          st_nxt.bit_idx = `SASQ_RES_TOP_IDX;
          st_nxt.work = 12'h000;
          st_nxt.dac = 12'h800;
          st_nxt.ch_cyc = 9'h000;
          st_nxt.seq_cyc = 11'h000;
          st_nxt.rd_ptr = 2'h0;
          st_nxt.end_n = 1'b1;
        end
      end
      SQ_CONV: begin
        // trigger edges are simply not looked at here
        st_nxt.ch_cyc = st_r.ch_cyc + 9'h001;
        st_nxt.seq_cyc = st_r.seq_cyc + 11'h001;
        if (conv_tick) begin
          st_nxt.work = cmp_hi ? trial : st_r.work;
          st_nxt.bit_idx = st_r.bit_idx - 4'h1;
          st_nxt.dac = (cmp_hi ? trial : st_r.work) | 12'(12'h001 << (st_r.bit_idx - 4'h1));
        end
        if (store) begin
          st_nxt.mem[st_r.ch_idx] = (conv_tick && cmp_hi) ? trial : st_r.work;
          st_nxt.work = 12'h000;
          st_nxt.bit_idx = `SASQ_RES_TOP_IDX;
          st_nxt.dac = 12'h800;
          st_nxt.ch_cyc = 9'h000;
          if (st_r.ch_idx == st_r.seq_last) begin
            st_nxt.state = SQ_IDLE;
            st_nxt.hold = 1'b0;
            // the end flag falling beats a read clearing it in the same cycle
            st_nxt.end_n = 1'b0;
          end else begin
            st_nxt.ch_idx = st_r.ch_idx + 2'h1;
          end
        end
      end
    endcase

    if (sys_rst) begin
      st_nxt = '0;
      st_nxt.state = SQ_IDLE;
      st_nxt.cs_m = 1'b1;
      st_nxt.cs_s = 1'b1;
      st_nxt.wr_m = 1'b1;
      st_nxt.wr_s = 1'b1;
      st_nxt.rd_m = 1'b1;
      st_nxt.rd_s = 1'b1;
      st_nxt.trg_m = 1'b1;
      st_nxt.trg_s = 1'b1;
      st_nxt.trg_p = 1'b1;
      st_nxt.mode = `SASQ_MODE_RESET;
      st_nxt.bit_idx = `SASQ_RES_TOP_IDX;
      st_nxt.end_n = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  // pins driven only while a qualified read is in progress
  assign result_bits_oe = st_r.rd_act & rd_now;
  assign result_bits_o = st_r.dout;
  assign end_of_seq_n = st_r.end_n;
  assign dac_code = st_r.dac;
  assign sample_hold = st_r.hold;
  assign bank_sel = st_r.seq_bank;
  assign chan_sel = st_r.ch_idx;
  assign power_down = st_r.mode[`SASQ_MODE_PDOWN_BIT];

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_seq_time_bound: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.state == SQ_CONV) |-> (st_r.seq_cyc < seq_lim))
    else $error("sequence exceeded its time budget");

  a_trigger_starts: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.state == SQ_IDLE && trg_rise && !power_down) |=> (st_r.state == SQ_CONV && sample_hold && chan_sel == 2'h0))
    else $error("trigger edge did not start a sequence");

  a_end_flag_falls: assert property (@(posedge clk) disable iff (sys_rst)
    (store && st_r.ch_idx == st_r.seq_last) |=> (!end_of_seq_n && !sample_hold))
    else $error("end flag not low after last conversion");

  a_shared_pins_in: assert property (@(posedge clk) disable iff (sys_rst)
    wr_now |-> !result_bits_oe)
    else $error("data pins driven during a write");

  a_read_word_order: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_now && !st_r.rd_act) |=> (result_bits_o == $past(st_r.mem[st_r.rd_ptr])))
    else $error("read returned the wrong stored word");

  a_trigger_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.state == SQ_CONV && trg_rise && !store) |=> (st_r.state == SQ_CONV && $stable(st_r.ch_idx)))
    else $error("trigger disturbed a running sequence");

  a_pointer_wraps: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.rd_act && !rd_now && st_r.rd_ptr == 2'h3 && !(st_r.state == SQ_IDLE && trg_rise)) |=> (st_r.rd_ptr == 2'h0))
    else $error("read pointer did not wrap after four reads");

  a_pointer_restart: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.state == SQ_IDLE && trg_rise && !power_down) |=> (st_r.rd_ptr == 2'h0))
    else $error("read pointer not reset by a new conversion");

  a_select_high_hiz: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.cs_s |-> (!result_bits_oe ##1 !st_r.rd_act))
    else $error("data pins driven with select high");

  a_mode_latched: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.wr_act && !wr_now) |=> (st_r.mode == $past(st_r.md_cap)) ##1 (wr_now || $stable(st_r.mode)))
    else $error("mode not latched on strobe release");

endmodule : sasq_sequencer

// ---- verif/sasq_ana_model.sv ----
// analog side model: eight inputs, four track/holds and the SAR comparator
`timescale 1ns/1ps

module sasq_ana_model (
  input wire logic [7:0][11:0] ana,
  input wire logic sample_hold,
  input wire logic bank_sel,
  input wire logic [1:0] chan_sel,
  input wire logic [11:0] dac_code,
  output logic cmp_hi
);
  // ---------------------------------------------------------------------------
  // track/holds
  // ---------------------------------------------------------------------------
  logic [3:0][11:0] held = '0;

  // all four channels of the chosen bank freeze together
  // bank select settles in the same step as hold rises, so wait a moment
  always @(posedge sample_hold) begin
    #0.1;
    for (int i = 0; i < 4; i++) begin
      held[i] = ana[bank_sel * 4 + i];
    end
  end

  // ideal comparator, so a correct SAR reproduces the held code exactly
  assign cmp_hi = (held[chan_sel] >= dac_code);
endmodule : sasq_ana_model

// ---- verif/tb.sv ----
// self-checking bench of the sampling sequencer
`timescale 1ns/1ps

module tb;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic clk = 0;
  logic sys_rst = 1;
  logic cs_n = 1;
  logic wr_n = 1;
  logic rd_n = 1;
  logic sample_trigger_n = 1;
  logic conv_clk_pin = 1;
  logic [1:0] mode_select_bits = '0;
  logic h_oe = 0;
  logic [1:0] h_hi = '0;
  logic [11:0] result_bits_o, dac_code, e;
  logic result_bits_oe, end_of_seq_n, sample_hold, bank_sel, power_down;
  logic int_clk_sel, cmp_hi, d0, d1;
  logic oe_q = 0;
  logic ext_run = 0;
  logic [1:0] chan_sel;
  logic [7:0][11:0] ana = '0;
  logic [3:0][11:0] exps;
  logic [11:0] expq[$];
  logic [31:0] lfsr_s = 32'hE2AB;
  int ext_cnt = 0;
  int num_errors = 0;
  int cmp_count = 0;

  // shared pins: device drives on reads, host on writes, else the inverse
  assign d0 = result_bits_oe ? result_bits_o[0] : (h_oe ? h_hi[0] : ~h_hi[0]);
  assign d1 = result_bits_oe ? result_bits_o[1] : (h_oe ? h_hi[1] : ~h_hi[1]);

  sasq_sequencer dut (
    .clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .sample_trigger_n(sample_trigger_n), .conv_clk_pin(conv_clk_pin),
    .mode_select_bits(mode_select_bits), .shared_result0_mode2_i(d0),
    .shared_result1_mode3_i(d1), .cmp_hi(cmp_hi), .result_bits_o(result_bits_o),
    .result_bits_oe(result_bits_oe), .end_of_seq_n(end_of_seq_n), .dac_code(dac_code),
    .sample_hold(sample_hold), .bank_sel(bank_sel), .chan_sel(chan_sel),
    .power_down(power_down), .int_clk_sel(int_clk_sel)
  );

  sasq_ana_model ana_mdl (
    .ana(ana), .sample_hold(sample_hold), .bank_sel(bank_sel),
    .chan_sel(chan_sel), .dac_code(dac_code), .cmp_hi(cmp_hi)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  // external clock: 50% duty, phase restarted by the trigger pulse
  always @(posedge clk) begin
    if (!ext_run) begin
      conv_clk_pin <= 1'b1;
    end else if (ext_cnt >= 9 || !sample_trigger_n) begin
      ext_cnt <= 0;
      conv_clk_pin <= !sample_trigger_n ? 1'b0 : ~conv_clk_pin;
    end else begin
      ext_cnt <= ext_cnt + 1;
    end
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic check(logic [11:0] seen, logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // stimulus source: one step of the bench shift register
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  // mode write; csf lets select rise before the write strobe
  task automatic wr_mode(logic [3:0] m, bit csf, bit sel);
    cs_n = !sel;
    wr_n = 0;
    h_oe = 1;
    {h_hi, mode_select_bits} = m;
    tick(4);
    if (csf) cs_n = 1;
    else wr_n = 1;
    tick(2);
    cs_n = 1;
    wr_n = 1;
    tick(1);
    h_oe = 0;
    tick(3);
  endtask : wr_mode

  task automatic rd_one(logic [11:0] x);
    expq.push_back(x);
    cs_n = 0;
    rd_n = 0;
    tick(5);
    rd_n = 1;
    tick(4);
    cs_n = 1;
    tick(2);
  endtask : rd_one

  task automatic trig();
    sample_trigger_n = 0;
    tick(3);
    sample_trigger_n = 1;
  endtask : trig

  // one sequence; a second trigger while busy must change nothing
  task automatic conv(logic [3:0] m);
    int c;
    for (int i = 0; i < 8; i++) begin
      lfsr_s = lfsr_next(lfsr_s);
      ana[i] = lfsr_s[11:0];
    end
    for (int i = 0; i < 4; i++) exps[i] = ana[m[2] * 4 + i];
    trig();
    c = 0;
    while (sample_hold !== 1'b1 && c < 10) begin
      tick(1);
      c++;
    end
    ana = ~ana; // moving inputs must not reach held values
    trig();
    c += 3; // the busy trigger takes three cycles of the sequence time
    while (end_of_seq_n !== 1'b0 && c < 2100) begin
      tick(1);
      c++;
    end
    check(c <= 500 * (m[1:0] + 1) + 8, 1);
    check(sample_hold, 0);
    check(bank_sel, m[2]);
    tick(20);
    check(sample_hold, 0);
  endtask : conv

  // result monitor: takes the oldest note when a read starts
  always @(posedge clk) begin
    oe_q <= result_bits_oe;
    if (result_bits_oe === 1'b1 && oe_q === 1'b0) begin
      if (expq.size() == 0) begin
        num_errors++;
        $display("BAD %0t unexpected read data", $time);
      end else begin
        e = expq.pop_front();
        check(result_bits_o, e);
        check({d1, d0}, e[1:0]);
      end
    end
  end

  initial begin
    #200000;
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    tick(6);
    sys_rst = 0;
    tick(80);
    check(int_clk_sel, 1);
    check(end_of_seq_n, 1);
    conv(4'h0);
    rd_one(exps[0]);
    // every channel count and bank; four channels read five times to wrap
    for (int m = 1; m < 8; m++) begin
      wr_mode(4'(m), m[0], 1);
      conv(4'(m));
      for (int i = 0; i < ((m % 4) == 3 ? 5 : (m % 4) + 1); i++) rd_one(exps[i % 4]);
    end
    // strobes with select high are ignored
    rd_n = 0;
    tick(6);
    check(result_bits_oe, 0);
    rd_n = 1;
    wr_mode(4'h8, 0, 0);
    check(power_down, 0);
    wr_mode(4'h8, 1, 1);
    check(power_down, 1);
    trig();
    tick(10);
    check(sample_hold, 0);
    // external conversion clock, four channels of bank A
    wr_mode(4'h3, 0, 1);
    ext_run = 1;
    tick(40);
    check(int_clk_sel, 0);
    conv(4'h3);
    for (int i = 0; i < 4; i++) rd_one(exps[i]);
    ext_run = 0;
    tick(4);
    check(expq.size(), 0);
    end_sim();
  end
endmodule : tb
